// file: rtl/stm_pkg.sv
// Package: register map, field layout and types of the standard timer
package stm_pkg;

    // Register byte addresses
    localparam logic [7:0] ctrl0_off = 8'h00;
    localparam logic [7:0] ctrl1_off = 8'h04;
    localparam logic [7:0] cnt_lo_off = 8'h08;
    localparam logic [7:0] cnt_hi_off = 8'h0C;
    localparam logic [7:0] cmpa_lo_off = 8'h10;
    localparam logic [7:0] cmpa_hi_off = 8'h14;
    localparam logic [7:0] period_off = 8'h18;
    localparam logic [7:0] status_off = 8'h1C;

    // Field positions
    localparam int enable_bit = 3;
    localparam int mode_hi_bit = 7;
    localparam int mode_lo_bit = 6;
    localparam int pin_func_hi_bit = 5;
    localparam int pin_func_lo_bit = 4;
    localparam int level_ctrl_bit = 3;
    localparam int invert_bit = 2;
    localparam int swap_bit = 1;
    localparam int clear_sel_bit = 0;
    localparam int flag_a_bit = 0;
    localparam int flag_p_bit = 1;

    // Reset values
    localparam logic [7:0] byte_reset = 8'h00;
    localparam logic [15:0] count_reset = 16'h0000;

    typedef enum logic [1:0] {
        mode_compare = 2'b00,
        mode_capture = 2'b01,
        mode_pwm = 2'b10,
        mode_timer = 2'b11
    } mode_e;

    // Pin function codes
    localparam logic [1:0] pin_nochange = 2'b00;
    localparam logic [1:0] pin_low = 2'b01;
    localparam logic [1:0] pin_high = 2'b10;
    localparam logic [1:0] pin_toggle = 2'b11;
    localparam logic [1:0] pwm_inactive = 2'b00;
    localparam logic [1:0] pwm_active = 2'b01;
    localparam logic [1:0] pwm_run = 2'b10;
    localparam logic [1:0] pwm_single = 2'b11;

    typedef struct packed {
        mode_e mode;
        logic [1:0] pin_func;
        logic output_level_control;
        logic output_invert;
        logic duty_period_swap;
        logic counter_clear_select;
    } ctrl1_s;

    typedef struct packed {
        logic compare_a_match_flag;
        logic period_match_flag;
    } match_s;

endpackage

// file: rtl/stm_counter.sv
// Counter and both comparators of the standard timer
`timescale 1ns/10ps
module stm_counter #(
    parameter int width = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic module_enable,
    input wire logic enable_rise,
    input wire logic clear_on_a,
    input wire logic [width-1:0] compare_a_value,
    input wire logic [7:0] period_compare,
    output logic [width-1:0] count,
    output logic match_a,
    output logic match_p
);
    import stm_pkg::*;

    logic [width-1:0] count_r;
    logic [width-1:0] count_nxt;
    logic ovf;

    // ==========================================================
    // Comparators
    always_comb
    begin
        match_a = module_enable && (count_r == compare_a_value);
        ovf = &count_r;
        if (period_compare == 8'h00)
        begin
            match_p = module_enable && ovf;
        end
        else
        begin
            // Match on the last count of the period, so the clear yields N*256 clocks
            match_p = module_enable && (count_r[width-1 -: 8] == (period_compare - 8'h01))
                && (&count_r[width-9:0]);
        end
    end

    // ==========================================================
    // Counter
    always_comb
    begin
        count_nxt = count_r;
        if (enable_rise)
        begin
            count_nxt = '0;
        end
        else if (module_enable)
        begin
            if ((clear_on_a && match_a) || (!clear_on_a && match_p))
            begin
                count_nxt = '0;
            end
            else
            begin
                count_nxt = count_r + 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            count_r <= '0;
        end
        else
        begin
            count_r <= count_nxt;
        end
    end

    assign count = count_r;

endmodule // stm_counter

// file: rtl/stm_top.sv
// Standard timer compare/output control with AHB-Lite registers
`timescale 1ns/10ps
module stm_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic timer_output_pin,
    output logic timer_output_pin_n,
    output stm_pkg::match_s match_flags
);
    import stm_pkg::*;

    // ==========================================================
    // Bus address phase capture
    logic wr_pend_r;
    logic wr_pend_nxt;
    logic [7:0] addr_r;
    logic [7:0] addr_nxt;
    logic take;

    assign take = hsel && hready && htrans[1];

    always_comb
    begin
        wr_pend_nxt = take && hwrite;
        addr_nxt = take ? haddr[7:0] : addr_r;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r <= 1'b0;
            addr_r <= 8'h00;
        end
        else
        begin
            wr_pend_r <= wr_pend_nxt;
            addr_r <= addr_nxt;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ==========================================================
    // Registers
    logic enable_r;
    logic enable_nxt;
    ctrl1_s ctrl_r;
    ctrl1_s ctrl_nxt;
    logic [15:0] cmpa_r;
    logic [15:0] cmpa_nxt;
    logic [7:0] period_r;
    logic [7:0] period_nxt;
    match_s flags_r;
    match_s flags_nxt;
    logic enable_d_r;
    logic enable_rise;
    logic [15:0] count;
    logic match_a;
    logic match_p;
    logic clear_on_a;
    logic flag_clr_a;
    logic flag_clr_p;

    always_comb
    begin
        enable_nxt = enable_r;
        ctrl_nxt = ctrl_r;
        cmpa_nxt = cmpa_r;
        period_nxt = period_r;
        flag_clr_a = 1'b0;
        flag_clr_p = 1'b0;
        if (wr_pend_r)
        begin
            case (addr_r)
                ctrl0_off: enable_nxt = hwdata[enable_bit];
                ctrl1_off: ctrl_nxt = ctrl1_s'(hwdata[7:0]);
                cmpa_lo_off: cmpa_nxt[7:0] = hwdata[7:0];
                cmpa_hi_off: cmpa_nxt[15:8] = hwdata[7:0];
                period_off: period_nxt = hwdata[7:0];
                status_off:
                begin
                    flag_clr_a = hwdata[flag_a_bit];
                    flag_clr_p = hwdata[flag_p_bit];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            enable_r <= 1'b0;
            ctrl_r <= ctrl1_s'(byte_reset);
            cmpa_r <= count_reset;
            period_r <= byte_reset;
            enable_d_r <= 1'b0;
        end
        else
        begin
            enable_r <= enable_nxt;
            ctrl_r <= ctrl_nxt;
            cmpa_r <= cmpa_nxt;
            period_r <= period_nxt;
            enable_d_r <= enable_r;
        end
    end

    assign enable_rise = enable_r && !enable_d_r;

    // ==========================================================
    // Counter clear source
    always_comb
    begin
        case (ctrl_r.mode)
            mode_compare: clear_on_a = ctrl_r.counter_clear_select;
            mode_timer: clear_on_a = ctrl_r.counter_clear_select;
            mode_pwm: clear_on_a = ctrl_r.duty_period_swap;
            default: clear_on_a = 1'b0;
        endcase
    end

    stm_counter #(
        .width(16)
    ) u_counter (
        .hclk(hclk),
        .hresetn(hresetn),
        .module_enable(enable_r),
        .enable_rise(enable_rise),
        .clear_on_a(clear_on_a),
        .compare_a_value(cmpa_r),
        .period_compare(period_r),
        .count(count),
        .match_a(match_a),
        .match_p(match_p)
    );

    // ==========================================================
    // Match flags, set wins over clear
    always_comb
    begin
        flags_nxt = flags_r;
        if (flag_clr_a)
        begin
            flags_nxt.compare_a_match_flag = 1'b0;
        end
        if (flag_clr_p)
        begin
            flags_nxt.period_match_flag = 1'b0;
        end
        if (match_a && (cmpa_r != 16'h0000))
        begin
            flags_nxt.compare_a_match_flag = 1'b1;
        end
        if (match_p && !(clear_on_a && ctrl_r.mode != mode_pwm))
        begin
            flags_nxt.period_match_flag = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            flags_r <= '0;
        end
        else
        begin
            flags_r <= flags_nxt;
        end
    end

    assign match_flags = flags_r;

    // ==========================================================
    // Output waveform
    logic raw_r;
    logic raw_nxt;
    logic duty_hit;
    logic pin_nxt;
    logic pin_r;

    always_comb
    begin
        // Duty reached when counter is at or above the duty threshold
        if (ctrl_r.duty_period_swap)
        begin
            duty_hit = (period_r == 8'h00) ? 1'b0 : (count[15:8] >= period_r);
        end
        else
        begin
            duty_hit = (count >= cmpa_r);
        end
        raw_nxt = raw_r;
        if (enable_rise)
        begin
            raw_nxt = ctrl_r.output_level_control;
        end
        else if (enable_r && ctrl_r.mode == mode_compare && match_a)
        begin
            case (ctrl_r.pin_func)
                pin_low: raw_nxt = 1'b0;
                pin_high: raw_nxt = 1'b1;
                pin_toggle: raw_nxt = !raw_r;
                default: raw_nxt = raw_r;
            endcase
        end
        else if (ctrl_r.mode == mode_pwm && ctrl_r.pin_func == pwm_single)
        begin
            if (!enable_r || match_a)
            begin
                raw_nxt = !ctrl_r.output_level_control;
            end
        end
        case (ctrl_r.mode)
            mode_compare: pin_nxt = raw_r ^ ctrl_r.output_invert;
            mode_pwm:
            begin
                case (ctrl_r.pin_func)
                    pwm_inactive: pin_nxt = !ctrl_r.output_level_control;
                    pwm_active: pin_nxt = ctrl_r.output_level_control;
                    pwm_run: pin_nxt = enable_r && !duty_hit ?
                        ctrl_r.output_level_control : !ctrl_r.output_level_control;
                    default: pin_nxt = raw_r;
                endcase
                pin_nxt = pin_nxt ^ ctrl_r.output_invert;
            end
            default: pin_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            raw_r <= 1'b0;
            pin_r <= 1'b0;
        end
        else
        begin
            raw_r <= raw_nxt;
            pin_r <= pin_nxt;
        end
    end

    assign timer_output_pin = pin_r;
    assign timer_output_pin_n = !pin_r;

    // ==========================================================
    // Read data
    always_comb
    begin
        hrdata = 32'h0000_0000;
        case (addr_r)
            ctrl0_off: hrdata[enable_bit] = enable_r;
            ctrl1_off: hrdata[7:0] = ctrl_r;
            cnt_lo_off: hrdata[7:0] = count[7:0];
            cnt_hi_off: hrdata[7:0] = count[15:8];
            cmpa_lo_off: hrdata[7:0] = cmpa_r[7:0];
            cmpa_hi_off: hrdata[7:0] = cmpa_r[15:8];
            period_off: hrdata[7:0] = period_r;
            status_off: hrdata[1:0] = {flags_r.period_match_flag, flags_r.compare_a_match_flag};
            default: hrdata = 32'h0000_0000;
        endcase
    end

endmodule // stm_top

// file: test/stm_chk.sv
// Checker of bus and pin behaviour of the standard timer
`timescale 1ns/10ps
module stm_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic timer_output_pin,
    input wire logic timer_output_pin_n,
    input wire stm_pkg::match_s match_flags
);
    import stm_pkg::*;
    // ====
    // Register shadow
    logic wr_r, wr_nxt, rd_r, rd_nxt, en_r, en_nxt;
    logic [7:0] ad_r, ad_nxt;
    ctrl1_s c1_r, c1_nxt;
    always_comb
    begin
        wr_nxt = hsel && hready && htrans[1] && hwrite;
        rd_nxt = hsel && hready && htrans[1] && !hwrite;
        ad_nxt = haddr[7:0];
        en_nxt = (wr_r && ad_r == ctrl0_off) ? hwdata[enable_bit] : en_r;
        c1_nxt = (wr_r && ad_r == ctrl1_off) ? ctrl1_s'(hwdata[7:0]) : c1_r;
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            en_r <= 1'b0;
            ad_r <= 8'h00;
            c1_r <= ctrl1_s'(8'h00);
        end
        else
        begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            en_r <= en_nxt;
            ad_r <= ad_nxt;
            c1_r <= c1_nxt;
        end
    end
    logic sel_a;
    assign sel_a = c1_r.counter_clear_select && c1_r.mode == mode_compare;
    // ====
    // Assertions
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    sequence s_start;
        $rose(en_r) && (c1_r.mode == mode_compare ||
            (c1_r.mode == mode_pwm && c1_r.pin_func == pwm_single));
    endsequence
    sequence s_level;
        timer_output_pin == (c1_r.output_level_control ^ c1_r.output_invert);
    endsequence
    AST_START: assert property (s_start |-> ##[1:2] s_level)
        else $error("pin not at start level");
    AST_TIMER: assert property (c1_r.mode == mode_timer && $past(c1_r.mode) == mode_timer
        |-> !timer_output_pin)
        else $error("pin driven in timer mode");
    AST_NO_P: assert property (sel_a && $past(sel_a) && $past(sel_a, 2)
        |-> !$rose(match_flags.period_match_flag))
        else $error("period flag with clear on A");
    AST_OFF: assert property (!en_r && $past(!en_r) && $past(!en_r, 2)
        |-> !$rose(match_flags.compare_a_match_flag))
        else $error("match while disabled");
    AST_PIN_N: assert property (timer_output_pin_n == !timer_output_pin)
        else $error("inverse pin wrong");
    AST_BUS: assert property (hreadyout && !hresp)
        else $error("bus response wrong");
    AST_UPPER: assert property (rd_r |-> hrdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    AST_STICKY: assert property ($fell(match_flags.compare_a_match_flag)
        |-> $past(wr_r && ad_r == status_off && hwdata[flag_a_bit]))
        else $error("flag fell without clear");
endmodule // stm_chk
bind stm_top stm_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer_output_pin(timer_output_pin), .timer_output_pin_n(timer_output_pin_n),
    .match_flags(match_flags));

// file: test/stm_top_tb.sv
// Testbench of the standard timer
`timescale 1ns/10ps
module stm_top_tb;
    import stm_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    logic hready, hreadyout, hresp, pin, pin_n;
    logic [31:0] hrdata, rd, rd2;
    match_s flags;
    int num_errors = 0;
    int num_checks = 0;
    assign hready = hreadyout;
    always #20 hclk = ~hclk;
    stm_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timer_output_pin(pin),
        .timer_output_pin_n(pin_n), .match_flags(flags));
    // ====
    // Common tasks
    task test_done;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task run(input logic [7:0] c);
        wr(ctrl0_off, 32'h00000000);
        wr(status_off, 32'h00000003);
        wr(ctrl1_off, {24'h000000, c});
        wr(ctrl0_off, 32'h00000008);
    endtask
    // ====
    // Scenarios
    task t_regs;
        logic [7:0] ra [6];
        ra = '{cnt_lo_off, cnt_hi_off, cmpa_lo_off, cmpa_hi_off, period_off, 8'h20};
        foreach (ra[i])
        begin
            xfer(ra[i], 1'b0, 32'h00000000);
            check(rd, 32'h00000000);
        end
        wr(cmpa_lo_off, 32'h000000A5);
        wr(cmpa_hi_off, 32'h0000005A);
        wr(cnt_lo_off, 32'h000000FF);
        xfer(cmpa_lo_off, 1'b0, 32'h00000000);
        check(rd, 32'h000000A5);
        xfer(cmpa_hi_off, 1'b0, 32'h00000000);
        check(rd, 32'h0000005A);
        xfer(cnt_lo_off, 1'b0, 32'h00000000);
        check(rd, 32'h00000000);
    endtask
    task t_count;
        run(8'h00);
        xfer(cnt_lo_off, 1'b0, 32'h00000000);
        rd2 = rd;
        xfer(cnt_lo_off, 1'b0, 32'h00000000);
        check((rd - rd2) & 32'h000000FF, 32'h00000002);
        wr(ctrl0_off, 32'h00000000);
        xfer(cnt_lo_off, 1'b0, 32'h00000000);
        rd2 = rd;
        repeat (5) @(posedge hclk);
        xfer(cnt_lo_off, 1'b0, 32'h00000000);
        check(rd, rd2);
        wr(ctrl0_off, 32'h00000008);
        xfer(cnt_lo_off, 1'b0, 32'h00000000);
        check(32'(rd < 8), 32'h00000001);
    endtask
    task t_start;
        logic [7:0] cfg [4];
        logic e;
        cfg = '{8'h31, 8'h3D, 8'h35, 8'hB8};
        wr(cmpa_lo_off, 32'h00000000);
        wr(cmpa_hi_off, 32'h00000001);
        wr(period_off, 32'h00000001);
        foreach (cfg[i])
        begin
            e = cfg[i][3] ^ cfg[i][2];
            run(cfg[i]);
            repeat (3) @(posedge hclk);
            check(32'(pin), 32'(e));
            check(32'(pin_n), 32'(!e));
            if (!cfg[i][7])
            begin
                repeat (300) @(posedge hclk);
                check(32'(pin), 32'(!e));
                check(32'(flags), 32'h00000002);
            end
        end
    endtask
    task t_period;
        time t1;
        t1 = 0;
        wr(cmpa_hi_off, 32'h00000000);
        wr(period_off, 32'h00000002);
        run(8'h00);
        repeat (2)
        begin
            rd = 32'h00000000;
            for (int n = 0; n < 400 && !rd[flag_p_bit]; n++)
                xfer(status_off, 1'b0, 32'h00000000);
            t1 = $time - t1;
            wr(status_off, 32'h00000002);
        end
        check(32'((t1 / 40) inside {[510:514]}), 32'h00000001);
    endtask
    task pwm(input logic [7:0] c, input logic [15:0] a, input int n, input int e);
        int hits;
        hits = 0;
        wr(cmpa_lo_off, {24'h000000, a[7:0]});
        wr(cmpa_hi_off, {24'h000000, a[15:8]});
        wr(period_off, 32'h00000001);
        run(c);
        repeat (4) @(posedge hclk);
        repeat (n)
        begin
            @(posedge hclk);
            if (pin === (c[3] ^ c[2]))
                hits++;
        end
        check(32'(hits inside {[e - 2:e + 2]}), 32'h00000001);
    endtask
    initial
    begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_count();
        t_start();
        t_period();
        pwm(8'hA1, 16'h0040, 512, 128);
        pwm(8'hA9, 16'h0040, 512, 128);
        pwm(8'hAD, 16'h0040, 512, 128);
        pwm(8'hAA, 16'h0400, 1024, 256);
        run(8'hCC);
        repeat (20) @(posedge hclk);
        check(32'(pin), 32'h00000000);
        test_done();
    end
    initial
    begin
        #(40 * 30000);
        num_errors++;
        test_done();
    end
endmodule // stm_top_tb
